// ===== pkg/somc_pkg.sv
package somc_pkg;
  localparam int NCH = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OUT = 8'h04;
  localparam logic [7:0] ADDR_MAP_A = 8'h08;
  localparam logic [7:0] ADDR_MAP_B = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_DIAG = 8'h14;
  localparam logic [7:0] MAP_A_RST = 8'h04;
  localparam logic [7:0] MAP_B_RST = 8'h08;
  localparam logic [7:0] LIMP_MASK = 8'h0C;
  localparam int CTRL_ACT = 0;
  localparam int CTRL_RST = 1;
  localparam int CTRL_PWMA = 2;
  localparam int CTRL_PWMB = 3;
  localparam logic [1:0] MODE_LIMP = 2'h1;
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_ACTIVE = 2'h2;
  localparam logic [1:0] MODE_SLEEP = 2'h3;
  typedef enum logic [1:0] {SOMC_SLEEP, SOMC_IDLE, SOMC_ACTIVE, SOMC_LIMP} somc_state_t;
  typedef struct packed {
    logic supply_uv;
    logic logic_uv;
    logic logic_low;
    logic supply_ok;
  } somc_supply_t;
  typedef struct packed {
    logic supply_undervoltage_flag;
    logic logic_supply_low_flag;
    logic transmission_error_flag;
    logic open_load_on_flag;
    logic open_load_off_flag;
    logic [1:0] mode;
  } somc_status_t;
endpackage

// ===== core/somc_ctrl.sv
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module somc_ctrl
  import somc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic standby_select_pin,
  input wire logic [1:0] direct_input_pin,
  input wire somc_supply_t supply_in,
  input wire logic [NCH-1:0] channel_fault,
  input wire logic open_load_on_in,
  input wire logic open_load_off_in,
  input wire logic [NCH-1:0] output_status_monitor_in,
  input wire logic comm_error_in,
  output logic [NCH-1:0] channel_on,
  output logic diag_enable,
  output logic [1:0] op_mode
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [7:0] sync1;
  logic [7:0] sync2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else begin
      sync1 <= {open_load_off_in, open_load_on_in, comm_error_in, standby_select_pin,
                direct_input_pin, supply_in.logic_uv, supply_in.supply_uv};
      sync2 <= sync1;
    end
  end
  logic [NCH-1:0] osm1, osm2, flt1, flt2;
  logic lsup1, lsup2, sok1, sok2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osm1 <= '0;
      osm2 <= '0;
      flt1 <= '0;
      flt2 <= '0;
      lsup1 <= 1'b0;
      lsup2 <= 1'b0;
      sok1 <= 1'b0;
      sok2 <= 1'b0;
    end else begin
      osm1 <= output_status_monitor_in;
      osm2 <= osm1;
      flt1 <= channel_fault;
      flt2 <= flt1;
      lsup1 <= supply_in.logic_low;
      lsup2 <= lsup1;
      sok1 <= supply_in.supply_ok;
      sok2 <= sok1;
    end
  end
  logic s_vs_uv, s_vdd_uv, s_idle_pin, s_ter, s_open_load_on_flag, s_open_load_off_flag;
  logic [1:0] s_in;
  assign s_vs_uv = sync2[0];
  assign s_vdd_uv = sync2[1];
  assign s_in = sync2[3:2];
  assign s_idle_pin = sync2[4];
  assign s_ter = sync2[5];
  assign s_open_load_on_flag = sync2[6];
  assign s_open_load_off_flag = sync2[7];

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  // Mapping registers only steer channels, never the wake decision, so an input wakes
  // the device even with both maps empty.
  somc_state_t state, next_state;
  logic keep_active;
  logic [NCH-1:0] out_cmd;
  logic any_in, any_cmd, power_up, reg_reset, soft_rst;
  assign any_in = |s_in;
  assign any_cmd = |out_cmd;
  assign power_up = sok2 && (any_in || s_idle_pin);
  always_comb begin
    next_state = state;
    case (state)
      SOMC_SLEEP: begin
        if (power_up) begin
          if (!s_idle_pin) begin
            next_state = SOMC_LIMP;
          end else if (any_in) begin
            next_state = SOMC_ACTIVE;
          end else begin
            next_state = SOMC_IDLE;
          end
        end
      end
      SOMC_IDLE: begin
        if (!s_idle_pin) begin
          next_state = any_in ? SOMC_LIMP : SOMC_SLEEP;
        end else if ((any_in || any_cmd || keep_active) && !s_vdd_uv) begin
          next_state = SOMC_ACTIVE;
        end
      end
      SOMC_ACTIVE: begin
        if (!s_idle_pin) begin
          next_state = any_in ? SOMC_LIMP : SOMC_SLEEP;
        end else if (s_vdd_uv && !any_in) begin
          next_state = SOMC_IDLE;
        end else if (!keep_active && !any_in && !any_cmd) begin
          next_state = SOMC_IDLE;
        end
      end
      SOMC_LIMP: begin
        if (s_idle_pin) begin
          next_state = SOMC_ACTIVE;
        end else if (!any_in) begin
          next_state = SOMC_SLEEP;
        end
      end
      default: next_state = SOMC_SLEEP;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SOMC_SLEEP;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic wr_acc, rd_acc, wr_ok, limp, hard_reset;
  logic [7:0] map_a, map_b;
  logic pwm_a, pwm_b;
  logic uv_flag, low_flag, ter_flag, ter_pend;
  logic [NCH-1:0] err_flag;
  assign limp = (state == SOMC_LIMP);
  // Bus effects except the first-command error mark in Limp Home wait for the completing edge, so a two-cycle access acts only once.
  assign wr_acc = psel && penable && pwrite && pready;
  assign rd_acc = psel && penable && !pwrite && pready;
  assign wr_ok = wr_acc && !limp && state != SOMC_SLEEP && !s_vdd_uv;
  assign soft_rst = wr_ok && paddr == ADDR_CTRL && pwdata[CTRL_RST];
  assign hard_reset = s_vdd_uv || !s_idle_pin || state == SOMC_SLEEP;
  assign reg_reset = hard_reset || soft_rst || limp;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keep_active <= 1'b0;
      pwm_a <= 1'b0;
      pwm_b <= 1'b0;
      out_cmd <= '0;
      map_a <= MAP_A_RST;
      map_b <= MAP_B_RST;
    end else if (reg_reset) begin
      keep_active <= 1'b0;
      pwm_a <= 1'b0;
      pwm_b <= 1'b0;
      out_cmd <= '0;
      map_a <= MAP_A_RST;
      map_b <= MAP_B_RST;
    end else if (wr_ok) begin
      case (paddr)
        ADDR_CTRL: begin
          keep_active <= pwdata[CTRL_ACT];
          pwm_a <= pwdata[CTRL_PWMA];
          pwm_b <= pwdata[CTRL_PWMB];
        end
        ADDR_OUT: out_cmd <= pwdata[NCH-1:0];
        ADDR_MAP_A: map_a <= pwdata[7:0];
        ADDR_MAP_B: map_b <= pwdata[7:0];
        default: out_cmd <= out_cmd;
      endcase
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  logic diag_read;
  assign diag_read = rd_acc && paddr == ADDR_DIAG;
  // Set wins over the readout clear so a supply dip during the read is kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_flag <= 1'b0;
      low_flag <= 1'b0;
    end else if (s_vdd_uv || state == SOMC_SLEEP) begin
      uv_flag <= 1'b0;
      low_flag <= 1'b0;
    end else if (limp) begin
      uv_flag <= 1'b1;
      low_flag <= 1'b1;
    end else begin
      if (s_vs_uv) begin
        uv_flag <= 1'b1;
      end else if (diag_read || soft_rst) begin
        uv_flag <= 1'b0;
      end
      if (lsup2) begin
        low_flag <= 1'b1;
      end else if (diag_read || soft_rst) begin
        low_flag <= 1'b0;
      end
    end
  end
  // Error flags survive Idle, soft reset and Limp Home; other hard resets clear them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_flag <= '0;
    end else if (hard_reset && !limp) begin
      err_flag <= '0;
    end else begin
      err_flag <= (err_flag | flt2) & ~(diag_read ? ~flt2 : '0);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ter_flag <= 1'b0;
      ter_pend <= 1'b0;
    end else begin
      // Entry into Limp Home falls inside a hard reset, so the pending mark must win it.
      if (next_state == SOMC_LIMP && !limp) begin
        ter_pend <= 1'b1;
      end else if (hard_reset && !limp) begin
        ter_pend <= 1'b0;
      end else if (psel && penable && limp) begin
        ter_pend <= 1'b0;
      end
      if (hard_reset && !limp) begin
        ter_flag <= 1'b0;
      end else if (s_ter || (psel && penable && limp && ter_pend)) begin
        ter_flag <= 1'b1;
      end else if (diag_read) begin
        ter_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Outputs and read data
  // ----------------------------------------
  somc_status_t stat;
  logic [1:0] next_mode;
  always_comb begin
    case (state)
      SOMC_LIMP: next_mode = MODE_LIMP;
      SOMC_ACTIVE: next_mode = MODE_ACTIVE;
      SOMC_IDLE: next_mode = MODE_IDLE;
      default: next_mode = MODE_SLEEP;
    endcase
  end
  assign stat.supply_undervoltage_flag = uv_flag;
  assign stat.logic_supply_low_flag = low_flag;
  assign stat.transmission_error_flag = ter_flag;
  assign stat.open_load_on_flag = s_open_load_on_flag && !limp;
  assign stat.open_load_off_flag = s_open_load_off_flag && !limp;
  assign stat.mode = next_mode;
  logic [NCH-1:0] pin_map, next_ch;
  always_comb begin
    pin_map = (s_in[0] ? map_a : 8'h00) | (s_in[1] ? map_b : 8'h00);
    case (state)
      SOMC_ACTIVE: next_ch = (sok2 && !s_vs_uv) ? (out_cmd | pin_map) : '0;
      SOMC_LIMP: next_ch = (s_vs_uv ? 8'h00 : pin_map) & LIMP_MASK;
      default: next_ch = '0;
    endcase
  end
  logic [31:0] next_rdata;
  always_comb begin
    case (paddr)
      ADDR_CTRL: next_rdata = {28'h0000000, pwm_b, pwm_a, 1'b0, keep_active};
      ADDR_OUT: next_rdata = {24'h000000, out_cmd};
      ADDR_MAP_A: next_rdata = {24'h000000, map_a};
      ADDR_MAP_B: next_rdata = {24'h000000, map_b};
      ADDR_STAT: next_rdata = {25'h0000000, stat};
      ADDR_DIAG: next_rdata = {16'h0000, err_flag, osm2};
      default: next_rdata = 32'h00000000;
    endcase
  end
  // Pready waits one access cycle so prdata can come straight from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      prdata <= (psel && !pwrite) ? next_rdata : 32'h00000000;
      pslverr <= psel && penable && !pready && (paddr > ADDR_DIAG || paddr[1:0] != 2'h0);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_on <= '0;
      diag_enable <= 1'b0;
      op_mode <= MODE_SLEEP;
    end else begin
      channel_on <= next_ch;
      diag_enable <= (state == SOMC_ACTIVE);
      op_mode <= next_mode;
    end
  end

  a_limp_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (state == SOMC_LIMP) |=> (channel_on & ~LIMP_MASK) == '0)
    else $error("channel outside limp mask on");
  a_sleep_off: assert property (@(posedge pclk) disable iff (!presetn)
    (state == SOMC_SLEEP) |=> channel_on == '0 && out_cmd == '0)
    else $error("sleep not quiet");
  a_limp_flags: assert property (@(posedge pclk) disable iff (!presetn)
    (state == SOMC_LIMP && $past(state) == SOMC_LIMP) |-> uv_flag && low_flag)
    else $error("limp flags not forced");
  a_limp_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (state == SOMC_LIMP) |=> op_mode == 2'h1)
    else $error("limp mode code wrong");
  a_limp_ro: assert property (@(posedge pclk) disable iff (!presetn)
    (state == SOMC_LIMP && wr_acc)
    |=> out_cmd == '0 && !keep_active && map_a == MAP_A_RST && map_b == MAP_B_RST)
    else $error("write taken in limp");
  a_keep_act: assert property (@(posedge pclk) disable iff (!presetn)
    (state == SOMC_ACTIVE && keep_active && s_idle_pin && !s_vdd_uv) |=> state == SOMC_ACTIVE)
    else $error("left active with keep bit");
  a_idle_exit: assert property (@(posedge pclk) disable iff (!presetn)
    (state == SOMC_ACTIVE && s_idle_pin && !keep_active && !any_in && !any_cmd)
    |=> state == SOMC_IDLE)
    else $error("active did not return idle");
  a_wake_act: assert property (@(posedge pclk) disable iff (!presetn)
    (state == SOMC_IDLE && s_idle_pin && any_in && !s_vdd_uv) |=> state == SOMC_ACTIVE)
    else $error("no wake to active");
  a_idle_off: assert property (@(posedge pclk) disable iff (!presetn)
    (state == SOMC_IDLE) ##1 (state == SOMC_IDLE) |-> channel_on == '0 && !diag_enable)
    else $error("idle drives channel");
  a_ter_first: assert property (@(posedge pclk) disable iff (!presetn)
    (state == SOMC_LIMP && ter_pend && psel && penable) |=> ter_flag)
    else $error("first limp command left error clear");
  a_err_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (state == SOMC_IDLE && !hard_reset && !diag_read)
    |=> (err_flag & $past(err_flag)) == $past(err_flag))
    else $error("error flag lost in idle");
endmodule
`default_nettype wire

// ===== tb/somc_host.sv
`timescale 1ns/1ps
`default_nettype none
module somc_host
  import somc_pkg::*;
(
  input wire logic pclk,
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic standby_select_pin,
  output logic [1:0] direct_input_pin,
  output var somc_supply_t supply_in,
  output logic [NCH-1:0] channel_fault,
  output logic open_load_on_in,
  output logic open_load_off_in,
  output logic [NCH-1:0] output_status_monitor_in,
  output logic comm_error_in
);
  // ------------------------------------------------------------
  // Host pins and bus master
  // ------------------------------------------------------------
  // Open-load inputs sit high so that a forced zero can be seen.
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {standby_select_pin, direct_input_pin, supply_in, channel_fault} = '0;
    {open_load_on_in, open_load_off_in, comm_error_in} = 3'h6;
    output_status_monitor_in = 8'h5A;
  end

  // The request is held until pready is sampled high at a rising edge.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask

  // Callers let the mode settle before the next bus command.
  task automatic set_pins(input logic stby, input logic [1:0] din, input somc_supply_t sup,
                          input logic [7:0] flt);
    @(posedge pclk);
    standby_select_pin <= stby;
    direct_input_pin <= din;
    supply_in <= sup;
    channel_fault <= flt;
  endtask
endmodule
`default_nettype wire

// ===== tb/switch_operation_mode_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module switch_operation_mode_control_tb
  import somc_pkg::*;
;
  // ------------------------------------------------------------
  // Bench signals and helpers
  // ------------------------------------------------------------
  localparam somc_supply_t SUP_OK = 4'h1;
  localparam somc_supply_t SUP_LOW = 4'hB;
  localparam somc_supply_t SUP_LUV = 4'h5;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stby, oln, olf, cerr;
  logic [7:0] paddr, flt, osm, channel_on;
  logic [31:0] pwdata, prdata;
  logic [1:0] din, op_mode;
  logic diag_enable;
  somc_supply_t sup;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  somc_ctrl DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .standby_select_pin(stby), .direct_input_pin(din), .supply_in(sup),
    .channel_fault(flt), .open_load_on_in(oln), .open_load_off_in(olf),
    .output_status_monitor_in(osm), .comm_error_in(cerr), .channel_on(channel_on),
    .diag_enable(diag_enable), .op_mode(op_mode));

  somc_host host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .standby_select_pin(stby), .direct_input_pin(din), .supply_in(sup), .channel_fault(flt),
    .open_load_on_in(oln), .open_load_off_in(olf), .output_status_monitor_in(osm),
    .comm_error_in(cerr));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic final_report;
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // The limit leaves ample room over the few hundred cycles the tests need.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      final_report;
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Pins reach the mode logic through two flops, so six cycles is settled.
  task automatic chk_pins(input logic [1:0] mode, input logic [7:0] ch);
    repeat (6) @(posedge pclk);
    #1;
    chk_reg({22'h0, op_mode, channel_on}, {22'h0, mode, ch});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    host.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    host.xfer(1'b0, a, 32'h0, q, e);
    chk_reg(q & mask, exp);
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic e;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk_pins(MODE_SLEEP, 8'h00);
    host.set_pins(1'b1, 2'b00, SUP_OK, 8'h00);
    chk_pins(MODE_IDLE, 8'h00);
    chk_reg({31'h0, diag_enable}, 32'h0);
    rd(ADDR_MAP_A, 32'hFF, {24'h0, MAP_A_RST});
    rd(ADDR_MAP_B, 32'hFF, {24'h0, MAP_B_RST});
    host.xfer(1'b0, 8'h18, 32'h0, q, e);
    chk_reg({31'h0, e}, 32'h1);
    wr(ADDR_OUT, 32'h01);
    chk_pins(MODE_ACTIVE, 8'h01);
    chk_reg({31'h0, diag_enable}, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_OUT, 32'h0);
    chk_pins(MODE_ACTIVE, 8'h00);
    wr(ADDR_CTRL, 32'hC);
    chk_pins(MODE_IDLE, 8'h00);
    rd(ADDR_CTRL, 32'hF, 32'hC);
    wr(ADDR_MAP_A, 32'h0);
    wr(ADDR_MAP_B, 32'h0);
    host.set_pins(1'b1, 2'b01, SUP_OK, 8'h00);
    chk_pins(MODE_ACTIVE, 8'h00);
    host.set_pins(1'b1, 2'b00, SUP_OK, 8'h00);
    chk_pins(MODE_IDLE, 8'h00);
    wr(ADDR_OUT, 32'h81);
    host.set_pins(1'b1, 2'b00, SUP_LOW, 8'h01);
    host.set_pins(1'b1, 2'b00, SUP_OK, 8'h00);
    chk_pins(MODE_ACTIVE, 8'h81);
    wr(ADDR_CTRL, 32'h2);
    chk_pins(MODE_IDLE, 8'h00);
    rd(ADDR_STAT, 32'h60, 32'h0);
    rd(ADDR_OUT, 32'hFF, 32'h0);
    rd(ADDR_CTRL, 32'hF, 32'h0);
    rd(ADDR_MAP_A, 32'hFF, {24'h0, MAP_A_RST});
    rd(ADDR_DIAG, 32'hFF00, 32'h0100);
    host.set_pins(1'b1, 2'b00, SUP_LOW, 8'h00);
    host.set_pins(1'b1, 2'b00, SUP_OK, 8'h00);
    chk_pins(MODE_IDLE, 8'h00);
    rd(ADDR_STAT, 32'h60, 32'h60);
    rd(ADDR_DIAG, 32'hFFFF, 32'h005A);
    rd(ADDR_STAT, 32'h60, 32'h0);
    wr(ADDR_OUT, 32'h01);
    chk_pins(MODE_ACTIVE, 8'h01);
    host.set_pins(1'b1, 2'b00, SUP_LUV, 8'h00);
    chk_pins(MODE_IDLE, 8'h00);
    host.set_pins(1'b1, 2'b00, SUP_OK, 8'h00);
    chk_pins(MODE_IDLE, 8'h00);
    rd(ADDR_OUT, 32'hFF, 32'h0);
    host.set_pins(1'b0, 2'b00, SUP_OK, 8'h00);
    chk_pins(MODE_SLEEP, 8'h00);
    host.set_pins(1'b0, 2'b01, SUP_OK, 8'h04);
    chk_pins(MODE_LIMP, 8'h04);
    rd(ADDR_STAT, 32'h7F, 32'h61);
    rd(ADDR_STAT, 32'h10, 32'h10);
    rd(ADDR_DIAG, 32'hFFFF, 32'h045A);
    wr(ADDR_OUT, 32'hFF);
    rd(ADDR_OUT, 32'hFF, 32'h0);
    host.set_pins(1'b0, 2'b11, SUP_OK, 8'h00);
    chk_pins(MODE_LIMP, LIMP_MASK);
    host.set_pins(1'b1, 2'b11, SUP_OK, 8'h00);
    chk_pins(MODE_ACTIVE, 8'h0C);
    final_report;
  end
endmodule
`default_nettype wire
